// file: host_port_pkg.sv
package host_port_pkg;
	// Host-side register select codes
	localparam logic [2:0] HSEL_CONTROL = 3'h0;
	localparam logic [2:0] HSEL_VECTOR = 3'h1;
	localparam logic [2:0] HSEL_STATUS = 3'h2;
	localparam logic [2:0] HSEL_UNUSED = 3'h3;
	localparam logic [2:0] HSEL_HIGH = 3'h5;
	localparam logic [2:0] HSEL_MID = 3'h6;
	localparam logic [2:0] HSEL_LOW = 3'h7;
	// Avalon register byte offsets
	localparam logic [4:0] REG_RX_WORD = 5'h00;
	localparam logic [4:0] REG_TX_WORD = 5'h04;
	localparam logic [4:0] REG_CTRL = 5'h08;
	localparam logic [4:0] REG_STAT = 5'h0C;
	localparam logic [4:0] REG_IRQ_STAT = 5'h10;
	localparam logic [4:0] REG_IRQ_MASK = 5'h14;
	// Host status register bit positions
	localparam int ST_RXF = 0;
	localparam int ST_TXE = 1;
	localparam int ST_TRANSFER_READY_FLAG = 2;
	localparam int ST_FA = 3;
	localparam int ST_FB = 4;
	localparam int ST_DMA = 6;
	localparam int ST_HOST_REQUEST_LINE = 7;
	// Host control register bit positions
	localparam int CT_FA = 3;
	localparam int CT_FB = 4;
	localparam int CT_DMA = 5;
	// Processor control bit positions
	localparam int PC_FA = 0;
	localparam int PC_FB = 1;
	localparam int PC_CMD_DONE = 2;
	// Processor status bit positions
	localparam int PS_RX_FULL = 0;
	localparam int PS_TX_EMPTY = 1;
	localparam int PS_CMD = 2;
	localparam int PS_HFA = 3;
	localparam int PS_HFB = 4;
	localparam int PS_DMA = 5;
	localparam int PS_VEC = 8;
	// Interrupt event bits
	localparam int IRQ_RX = 0;
	localparam int IRQ_TX = 1;
	localparam int IRQ_CMD = 2;
	localparam int IRQ_W = 3;
	localparam logic [6:0] VECTOR_RESET = 7'h00;
	// Synchroniser depth (two flops)
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_NS = 4;
	// Extra clock-high wait before request after a low-receive-byte read
	localparam int CLK_HIGH_NS = 2;
	localparam int RX_EXTRA_CYC = (CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : host_port_pkg

// file: host_sync.sv
`timescale 1ns/1ps
module host_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [WIDTH-1:0] async_in, // Asynchronous inputs
	output logic [WIDTH-1:0] sync_out // Synchronised outputs
);
	// Each bit has its own two-flop chain; first stage feeds only the second
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : host_sync

// file: dsp_host_byte_port.sv
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Operation
// - Status bits change in device clock; a racing host read settles next poll.
// - Clearing request cancels if early; vector unchanged in the same write.
// - Each host-controlled flag is synchronised to the device clock separately.
// - Device software reads the host flag pair twice and acts on agreement.
// - Host inputs are sampled into the device clock with bounded latency.
// - DMA mode: request drops on acknowledge, returns after sync plus a cycle.
// - Non-DMA: low-byte access drops request, returns after sync plus a cycle.
module dsp_host_byte_port (
	input wire logic sys_clk, // 250 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic host_port_enable_n, // Host enable, active low
	input wire logic host_dma_acknowledge_n, // DMA acknowledge, active low
	input wire logic host_read_write_line, // 1 read, 0 write
	input wire logic [2:0] host_register_select, // Host register select
	input wire logic [7:0] host_data_in, // Host data into the port
	output logic [7:0] host_data_out, // Host data out of the port
	output logic host_data_oe, // Host data bus driven
	output logic host_request_line_n, // Request, active low
	input wire logic [4:0] avs_address, // Avalon byte address
	input wire logic avs_read, // Avalon read
	input wire logic avs_write, // Avalon write
	input wire logic [31:0] avs_writedata, // Avalon write data
	input wire logic [3:0] avs_byteenable, // Avalon byte enables
	output logic [31:0] avs_readdata, // Avalon read data
	output logic avs_waitrequest, // Avalon wait
	output logic irq // Level interrupt
);
	typedef enum {REQ_IDLE, REQ_HOLD, REQ_WAIT} req_state_t;

	// Host-side registers, all in the device clock domain
	logic [23:0] host_rx_word;
	logic [23:0] host_tx_word;
	logic host_rx_full_flag;
	logic host_tx_empty_flag;
	logic host_to_proc_flag_a;
	logic host_to_proc_flag_b;
	logic dma_mode;
	logic host_command_request;
	logic [6:0] host_command_vector;
	// Processor-side registers
	logic [23:0] proc_side_receive_word;
	logic proc_rx_full_flag;
	logic proc_to_host_flag_a;
	logic proc_to_host_flag_b;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic bus_ack;
	req_state_t req_state;
	logic [1:0] req_wait;
	logic was_rx_low;

	// Host pins in through separate two-flop chains
	logic [13:0] host_pins_sync;
	host_sync #(.WIDTH(14)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({~host_port_enable_n, ~host_dma_acknowledge_n, host_read_write_line,
			host_register_select, host_data_in}),
		.sync_out(host_pins_sync)
	);
	wire en_s = host_pins_sync[13];
	wire ack_s = host_pins_sync[12];
	wire rw_s = host_pins_sync[11];
	wire [2:0] sel_s = host_pins_sync[10:8];
	wire [7:0] din_s = host_pins_sync[7:0];

	// Byte register selects: high, mid and low share one decode
	function automatic logic is_byte_sel(input logic [2:0] s);
		is_byte_sel = s >= host_port_pkg::HSEL_HIGH;
	endfunction : is_byte_sel

	function automatic logic is_low_sel(input logic [2:0] s);
		is_low_sel = s == host_port_pkg::HSEL_LOW;
	endfunction : is_low_sel

	logic access_d;
	wire access_s = dma_mode ? ack_s : en_s;
	// A transfer takes effect when the synchronised enable (acknowledge in DMA mode) is released
	wire access_end = !access_s && access_d;
	// DMA acknowledge addresses the low byte; the read/write line gives the direction
	wire [2:0] sel_eff = dma_mode ? host_port_pkg::HSEL_LOW : sel_s;
	wire host_wr = access_end && !rw_s;
	wire host_rd = access_end && rw_s;
	wire wr_low = host_wr && is_low_sel(sel_eff);
	wire rd_low = host_rd && is_low_sel(sel_eff);
	wire low_access = access_s && is_low_sel(sel_eff);
	// Write strobes; bytes are refused while the transmit word is still full
	wire host_byte_wr = host_wr && is_byte_sel(sel_eff) && host_tx_empty_flag;
	wire host_ctrl_wr = host_wr && sel_eff == host_port_pkg::HSEL_CONTROL;
	wire host_vec_wr = host_wr && sel_eff == host_port_pkg::HSEL_VECTOR;

	// Bus decode
	wire bus_req = (avs_read || avs_write) && !bus_ack;
	wire bus_wr = avs_write && bus_ack;
	wire bus_rd = avs_read && !bus_ack;
	wire sel_tx_w = avs_address == host_port_pkg::REG_TX_WORD;
	wire sel_rx_w = avs_address == host_port_pkg::REG_RX_WORD;
	wire sel_ctrl = avs_address == host_port_pkg::REG_CTRL;
	wire sel_ist = avs_address == host_port_pkg::REG_IRQ_STAT;
	wire sel_imask = avs_address == host_port_pkg::REG_IRQ_MASK;
	// Byte lane 0 enables every write; the transmit word also takes lanes 1 and 2
	wire bus_lane_wr = bus_wr && avs_byteenable[0];
	wire bus_ctrl_wr = bus_lane_wr && sel_ctrl;
	wire bus_mask_wr = bus_lane_wr && sel_imask;
	wire bus_ist_wr = bus_lane_wr && sel_ist;
	wire proc_tx_load = bus_lane_wr && sel_tx_w && host_rx_full_flag == 1'b0;
	wire proc_rx_take = bus_ack && avs_read && sel_rx_w;
	wire cmd_done = bus_ctrl_wr && avs_writedata[host_port_pkg::PC_CMD_DONE];

	function automatic logic [7:0] byte_of(input logic [23:0] w, input logic [2:0] s);
		case (s)
			host_port_pkg::HSEL_HIGH: byte_of = w[23:16];
			host_port_pkg::HSEL_MID: byte_of = w[15:8];
			default: byte_of = w[7:0];
		endcase
	endfunction : byte_of

	// Host-visible status byte; bits change only at device clock edges
	wire host_transfer_ready = host_tx_empty_flag && !proc_rx_full_flag;
	wire [7:0] host_status = {
		~host_request_line_n,
		dma_mode,
		1'b0,
		proc_to_host_flag_b,
		proc_to_host_flag_a,
		host_transfer_ready,
		host_tx_empty_flag,
		host_rx_full_flag
	};
	wire [7:0] host_control = {2'b00, dma_mode, host_to_proc_flag_b, host_to_proc_flag_a, 3'b000};
	wire [7:0] next_host_data =
		sel_eff == host_port_pkg::HSEL_STATUS ? host_status :
		sel_eff == host_port_pkg::HSEL_CONTROL ? host_control :
		sel_eff == host_port_pkg::HSEL_VECTOR ? {host_command_request, host_command_vector} :
		is_byte_sel(sel_eff) ? byte_of(host_rx_word, sel_eff) : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			access_d <= 1'b0;
			host_data_out <= 8'h00;
			host_data_oe <= 1'b0;
		end else begin
			access_d <= access_s;
			host_data_out <= next_host_data;
			host_data_oe <= access_s && rw_s;
		end
	end

	// Host writes: byte registers and control
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			host_tx_word <= 24'h000000;
			host_to_proc_flag_a <= 1'b0;
			host_to_proc_flag_b <= 1'b0;
			dma_mode <= 1'b0;
		end else if (host_wr) begin
			if (host_byte_wr) begin
				case (sel_eff)
					host_port_pkg::HSEL_HIGH: host_tx_word[23:16] <= din_s;
					host_port_pkg::HSEL_MID: host_tx_word[15:8] <= din_s;
					default: host_tx_word[7:0] <= din_s;
				endcase
			end
			if (host_ctrl_wr) begin
				host_to_proc_flag_a <= din_s[host_port_pkg::CT_FA];
				host_to_proc_flag_b <= din_s[host_port_pkg::CT_FB];
				dma_mode <= din_s[host_port_pkg::CT_DMA];
			end
		end
	end

	// Vector and command request
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			host_command_request <= 1'b0;
			host_command_vector <= host_port_pkg::VECTOR_RESET;
		end else if (host_vec_wr) begin
			host_command_request <= din_s[7];
			// Vector follows only while no command is pending and request is set
			if (!host_command_request && din_s[7]) begin
				host_command_vector <= din_s[6:0];
			end
		end else if (cmd_done) begin
			host_command_request <= 1'b0;
		end
	end

	// Word transfers in both directions
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			host_tx_empty_flag <= 1'b1;
			proc_rx_full_flag <= 1'b0;
			proc_side_receive_word <= 24'h000000;
		end else begin
			// A processor read must never be lost behind a host low-byte write
			if (proc_rx_take) begin
				proc_rx_full_flag <= 1'b0;
			end
			if (wr_low && host_tx_empty_flag) begin
				host_tx_empty_flag <= 1'b0;
			end else if (!host_tx_empty_flag && !proc_rx_full_flag) begin
				proc_side_receive_word <= host_tx_word;
				proc_rx_full_flag <= 1'b1;
				host_tx_empty_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			host_rx_word <= 24'h000000;
			host_rx_full_flag <= 1'b0;
		end else if (proc_tx_load) begin
			host_rx_word <= avs_writedata[23:0];
			host_rx_full_flag <= 1'b1;
		end else if (rd_low) begin
			host_rx_full_flag <= 1'b0;
		end
	end

	// Request pacing: drop during a low-byte access, return after sync plus one cycle
	wire req_cond = dma_mode ? (rw_s ? host_rx_full_flag : host_tx_empty_flag)
		: (host_rx_full_flag || host_tx_empty_flag);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			req_state <= REQ_IDLE;
			req_wait <= 2'b00;
			was_rx_low <= 1'b0;
			host_request_line_n <= 1'b1;
		end else begin
			case (req_state)
				REQ_IDLE: begin
					host_request_line_n <= !req_cond;
					if (low_access) begin
						req_state <= REQ_HOLD;
						host_request_line_n <= 1'b1;
					end
				end
				REQ_HOLD: begin
					host_request_line_n <= 1'b1;
					if (access_end) begin
						was_rx_low <= rw_s;
						req_wait <= 2'b00;
						req_state <= REQ_WAIT;
					end
				end
				REQ_WAIT: begin
					host_request_line_n <= 1'b1;
					req_wait <= req_wait + 2'b01;
					// One cycle after sync, plus clock-high slot for a receive read
					if (req_wait >= (was_rx_low ? 2'(host_port_pkg::RX_EXTRA_CYC) : 2'b00)) begin
						req_state <= REQ_IDLE;
					end
				end
				default: req_state <= REQ_IDLE;
			endcase
		end
	end

	// Processor-side status, each host bit from its own synchronised source
	// The processor's transmit side is empty once the host has taken its word
	wire proc_tx_empty = !host_rx_full_flag;
	wire [31:0] proc_status = {
		16'h0000,
		1'b0,
		host_command_vector,
		2'b00,
		dma_mode,
		host_to_proc_flag_b,
		host_to_proc_flag_a,
		host_command_request,
		proc_tx_empty,
		proc_rx_full_flag
	};
	wire [31:0] next_readdata =
		sel_rx_w ? {8'h00, proc_side_receive_word} :
		sel_tx_w ? {8'h00, host_rx_word} :
		sel_ctrl ? {29'h0, 1'b0, proc_to_host_flag_b, proc_to_host_flag_a} :
		avs_address == host_port_pkg::REG_STAT ? proc_status :
		sel_ist ? {28'h0, irq_stat} :
		sel_imask ? {28'h0, irq_mask} : 32'h00000000;

	// Avalon slave: one wait cycle, answer on the following edge
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_ack <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			bus_ack <= bus_req;
			avs_waitrequest <= !bus_req;
			if (bus_rd) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			proc_to_host_flag_a <= 1'b0;
			proc_to_host_flag_b <= 1'b0;
			irq_mask <= 4'h0;
		end else begin
			if (bus_ctrl_wr) begin
				proc_to_host_flag_a <= avs_writedata[host_port_pkg::PC_FA];
				proc_to_host_flag_b <= avs_writedata[host_port_pkg::PC_FB];
			end
			if (bus_mask_wr) begin
				irq_mask <= avs_writedata[3:0];
			end
		end
	end

	// Sticky events; a new event wins over a write-one clear
	logic [3:0] prev_ev;
	wire [3:0] ev_level = {
		host_to_proc_flag_a ^ host_to_proc_flag_b,
		host_command_request,
		host_tx_empty_flag,
		proc_rx_full_flag
	};
	wire [3:0] ev_rise = ev_level & ~prev_ev;
	wire [3:0] w1c = bus_ist_wr ? avs_writedata[3:0] : 4'h0;
	wire [3:0] next_irq_stat = (irq_stat & ~w1c) | ev_rise;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			// Start from the reset levels so that reset itself raises no event
			prev_ev <= 4'h2;
			irq_stat <= 4'h0;
			irq <= 1'b0;
		end else begin
			prev_ev <= ev_level;
			irq_stat <= next_irq_stat;
			irq <= |(next_irq_stat & irq_mask);
		end
	end
endmodule : dsp_host_byte_port

// file: dsp_host_byte_port_sva.sv
`timescale 1ns/1ps
module dsp_host_byte_port_sva (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic host_port_enable_n, // Host enable
	input wire logic host_dma_acknowledge_n, // DMA acknowledge
	input wire logic host_read_write_line, // Direction
	input wire logic [2:0] host_register_select, // Select
	input wire logic host_data_oe, // Data driven
	input wire logic host_request_line_n, // Request
	input wire logic avs_read, // Bus read
	input wire logic avs_write, // Bus write
	input wire logic avs_waitrequest, // Bus wait
	input wire logic irq // Interrupt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence low_held;
		!host_port_enable_n && host_register_select == host_port_pkg::HSEL_LOW;
	endsequence
	sequence low_access;
		low_held [*4] ##1 host_port_enable_n;
	endsequence
	AST_RESET_IDLE: assert property ($fell(rst) |-> avs_waitrequest && host_request_line_n && !host_data_oe && !irq)
		else $error("Outputs not idle after reset");
	AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("Bus answer not on second edge");
	AST_WAIT_SINGLE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("Bus answer longer than one cycle");
	AST_READ_DRIVE: assert property ((!host_port_enable_n && host_read_write_line) [*6] |-> host_data_oe)
		else $error("Read data not driven");
	AST_WRITE_QUIET: assert property ((!host_port_enable_n && !host_read_write_line) [*6] |-> !host_data_oe)
		else $error("Data driven during host write");
	AST_RELEASE_QUIET: assert property ((host_port_enable_n && host_dma_acknowledge_n) [*6]
		|-> !host_data_oe)
		else $error("Data driven while idle");
	AST_LOW_DROP: assert property (low_held [*4] |-> host_request_line_n)
		else $error("Request held during low byte access");
	AST_LOW_RETURN: assert property (low_access |-> host_request_line_n ##1 host_request_line_n)
		else $error("Request returned too soon");
	AST_ACK_DROP: assert property ((!host_dma_acknowledge_n) [*4] |-> host_request_line_n)
		else $error("Request held during acknowledge");
endmodule : dsp_host_byte_port_sva
bind dsp_host_byte_port dsp_host_byte_port_sva dsp_host_byte_port_sva_i (.sys_clk, .rst,
	.host_port_enable_n, .host_dma_acknowledge_n, .host_read_write_line, .host_register_select,
	.host_data_oe, .host_request_line_n, .avs_read, .avs_write, .avs_waitrequest, .irq);

// file: host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
	input wire logic sys_clk, // Clock
	input wire logic [7:0] host_data_out, // Byte from port
	output logic host_port_enable_n, // Enable
	output logic host_dma_acknowledge_n, // DMA acknowledge
	output logic host_read_write_line, // Direction
	output logic [2:0] host_register_select, // Select
	output logic [7:0] host_data_in // Byte to port
);
	initial begin
		host_port_enable_n = 1'b1;
		host_dma_acknowledge_n = 1'b1;
		host_read_write_line = 1'b1;
		host_register_select = 3'h0;
		host_data_in = 8'h5A;
	end
	task automatic access(input logic rd, input logic [2:0] sel, input logic [7:0] wd,
			output logic [7:0] rv);
		host_read_write_line <= rd;
		host_register_select <= sel;
		host_data_in <= rd ? ~host_data_in : wd;
		@(posedge sys_clk);
		host_port_enable_n <= 1'b0;
		repeat (7) @(posedge sys_clk);
		rv = host_data_out;
		host_port_enable_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		host_data_in <= ~host_data_in;
		repeat (6) @(posedge sys_clk);
	endtask : access
	task automatic dma_ack();
		host_dma_acknowledge_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		host_dma_acknowledge_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask : dma_ack
endmodule : host_cpu_model

// file: tb_dsp_host_byte_port.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module tb_dsp_host_byte_port;
	logic sys_clk, rst, en_n, ack_n, rw, oe, req_n, avs_read, avs_write, avs_waitrequest, irq;
	logic [2:0] sel;
	logic [7:0] din, dout, hb, hb2;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, rd2;
	int fails = 0;
	int checks = 0;
	host_cpu_model host_cpu_model_i (.sys_clk(sys_clk), .host_data_out(dout),
		.host_port_enable_n(en_n), .host_dma_acknowledge_n(ack_n),
		.host_read_write_line(rw), .host_register_select(sel), .host_data_in(din));
	dsp_host_byte_port dsp_host_byte_port_i (.sys_clk(sys_clk), .rst(rst),
		.host_port_enable_n(en_n), .host_dma_acknowledge_n(ack_n), .host_read_write_line(rw),
		.host_register_select(sel), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
		.host_request_line_n(req_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic complete_run();
		if (fails == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		if (wr) avs_write <= 1'b1;
		else avs_read <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
		if (n >= 50) begin
			fails++;
			complete_run();
		end
	endtask : bus
	task automatic wait_proc(input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, host_port_pkg::REG_STAT, 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 40);
		`CHK(rd[b], 1'b1)
		if (rd[b] !== 1'b1) complete_run();
	endtask : wait_proc
	task automatic host(input logic r, input logic [2:0] s, input logic [7:0] w);
		host_cpu_model_i.access(r, s, w, hb);
	endtask : host
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		host(1'b1, host_port_pkg::HSEL_STATUS, 8'h00);
		`CHK(hb[1:0], 2'h2)
		host(1'b0, host_port_pkg::HSEL_HIGH, 8'h12);
		host(1'b0, host_port_pkg::HSEL_MID, 8'h34);
		host(1'b0, host_port_pkg::HSEL_LOW, 8'h56);
		wait_proc(host_port_pkg::PS_RX_FULL);
		bus(1'b0, host_port_pkg::REG_RX_WORD, 32'h0);
		`CHK(rd, 32'h00123456)
		bus(1'b1, host_port_pkg::REG_TX_WORD, 32'h00A5C3E1);
		for (int n = 0; n < 20 && hb[host_port_pkg::ST_RXF] !== 1'b1; n++)
			host(1'b1, host_port_pkg::HSEL_STATUS, 8'h00);
		`CHK(hb[host_port_pkg::ST_RXF], 1'b1)
		if (hb[host_port_pkg::ST_RXF] !== 1'b1) complete_run();
		host(1'b1, host_port_pkg::HSEL_HIGH, 8'h00);
		`CHK(hb, 8'hA5)
		host(1'b1, host_port_pkg::HSEL_MID, 8'h00);
		`CHK(hb, 8'hC3)
		host(1'b1, host_port_pkg::HSEL_LOW, 8'h00);
		`CHK(hb, 8'hE1)
		host(1'b0, host_port_pkg::HSEL_CONTROL, 8'h18);
		wait_proc(host_port_pkg::PS_HFB);
		rd2 = rd;
		bus(1'b0, host_port_pkg::REG_STAT, 32'h0);
		`CHK(rd[4:3], rd2[4:3])
		`CHK(rd[4:3], 2'h3)
		bus(1'b1, host_port_pkg::REG_CTRL, 32'h3);
		repeat (8) @(posedge sys_clk);
		host(1'b1, host_port_pkg::HSEL_STATUS, 8'h00);
		hb2 = hb;
		host(1'b1, host_port_pkg::HSEL_STATUS, 8'h00);
		`CHK(hb[4:3], hb2[4:3])
		`CHK(hb[4:3], 2'h3)
		bus(1'b1, host_port_pkg::REG_IRQ_MASK, 32'h4);
		host(1'b0, host_port_pkg::HSEL_VECTOR, 8'h95);
		wait_proc(host_port_pkg::PS_CMD);
		`CHK(rd[14:8], 7'h15)
		`CHK(irq, 1'b1)
		bus(1'b0, host_port_pkg::REG_IRQ_STAT, 32'h0);
		`CHK(rd, 32'h00000007)
		host(1'b0, host_port_pkg::HSEL_VECTOR, 8'h15);
		bus(1'b1, host_port_pkg::REG_CTRL, 32'h7);
		bus(1'b1, host_port_pkg::REG_IRQ_STAT, 32'hF);
		bus(1'b0, host_port_pkg::REG_STAT, 32'h0);
		`CHK(rd[14:8], 7'h15)
		`CHK(irq, 1'b0)
		bus(1'b0, 5'h18, 32'h0);
		`CHK(rd, 32'h0)
		host(1'b0, host_port_pkg::HSEL_CONTROL, 8'h38);
		wait_proc(host_port_pkg::PS_DMA);
		host_cpu_model_i.dma_ack();
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		bus(1'b0, host_port_pkg::REG_STAT, 32'h0);
		`CHK(rd, 32'h00000002)
		host(1'b1, host_port_pkg::HSEL_STATUS, 8'h00);
		`CHK(hb, 8'h86)
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		complete_run();
	end
endmodule : tb_dsp_host_byte_port
